// ### flps_defines.svh
/*
  flps_defines.svh: offsets, field positions, reset values, command codes
  and timing counts of the flash latch program sequencer.
  Assumes a 25 MHz core clock; included by bare name.
*/
`ifndef FLPS_DEFINES_SVH
`define FLPS_DEFINES_SVH
`define FLPS_CTRL_OFS   8'h00
`define FLPS_CTRL_RST   8'h00
`define FLPS_BUSY_BIT   0
`define FLPS_FMOD_LSB   1
`define FLPS_MAP_BIT    3
`define FLPS_CMD_LSB    4
`define FLPS_CMD_FIRST  4'h5
`define FLPS_CMD_SECOND 4'hA
`define FLPS_MODE_USER  2'h0
`define FLPS_MODE_XROW  2'h1
`define FLPS_MODE_HSB   2'h2
`define FLPS_LAST_IDX   7'h7F
`define FLPS_XROW_BASE  16'hFF80
`define FLPS_HSB_ADDR   16'h0000
`define FLPS_HSB_RST    8'hFB
`define FLPS_LB_MASK    8'h07
`define FLPS_BARRED     8'hFF
`define FLPS_ERASED     8'hFF
`define FLPS_CLK_MHZ    25
`define FLPS_ERASE_NS   2000
`define FLPS_PROG_NS    1000
`define FLPS_ERASE_CYC  ((`FLPS_ERASE_NS * `FLPS_CLK_MHZ + 999) / 1000)
`define FLPS_PROG_CYC   ((`FLPS_PROG_NS * `FLPS_CLK_MHZ + 999) / 1000)
`endif

// ### flps_pkg.sv
/*
  flps_pkg.sv: types of the flash latch program sequencer.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package flps_pkg;
    typedef enum logic [1:0]
    {
        FLPS_IDLE  = 2'b00,
        FLPS_ERASE = 2'b01,
        FLPS_PROG  = 2'b10,
        FLPS_DONE  = 2'b11
    } flps_state_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } flps_reg_req_t;
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } flps_latch_wr_t;
    typedef struct packed {
        logic        rd;
        logic        from_ext;
        logic [15:0] addr;
    } flps_code_rd_t;
    typedef struct packed {
        logic        erase;
        logic        prog;
        logic [14:0] addr;
        logic [7:0]  data;
    } flps_flash_op_t;
    typedef struct packed {
        logic [2:0] level;
        logic       ext_read_bar;
        logic       acc_latch;
        logic       par_prog_dis;
        logic       par_verify_dis;
        logic       roll_block;
    } flps_prot_t;
endpackage : flps_pkg
`default_nettype wire

// ### flps_lock_decode.sv
/*
  flps_lock_decode.sv: turns the three lock bits into a protection level
  and its restrictions. A programmed bit reads 0.
  Assumes lock bits come from flip-flops on the same clock.
*/
`default_nettype none
module flps_lock_decode
(
    // lock bits, first in bit 0
    input  wire logic [2:0]           lock_bits_in,
    // decoded protection
    output var  flps_pkg::flps_prot_t prot_out
);
    import flps_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // the most restrictive programmed bit wins, so a stray extra bit
    // can never loosen protection
    always_comb
    begin
        prot_out = '0;
        prot_out.level = 3'h1;
        if (!lock_bits_in[2])
        begin
            prot_out.level = 3'h4;
        end
        else if (!lock_bits_in[1])
        begin
            prot_out.level = 3'h3;
        end
        else if (!lock_bits_in[0])
        begin
            prot_out.level = 3'h2;
        end
        prot_out.ext_read_bar   = (prot_out.level >= 3'h2);
        prot_out.acc_latch      = (prot_out.level >= 3'h2);
        prot_out.par_prog_dis   = (prot_out.level >= 3'h2);
        prot_out.par_verify_dis = (prot_out.level >= 3'h3);
        prot_out.roll_block     = (prot_out.level == 3'h4);
    end
endmodule : flps_lock_decode
`default_nettype wire

// ### flps_sequencer.sv
/*
  flps_sequencer.sv: column latches, two-byte launch command, erase then
  program sequencer, extra row and security byte storage, code-space
  read mapping and lock-bit protection.
  Assumes the CPU core on the same clock drives the register, latch and
  code-read ports; the user array macro answers reads in the same cycle.
*/
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
`include "flps_defines.svh"
module flps_sequencer
(
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     rstn_in,
    // register port
    input  wire flps_pkg::flps_reg_req_t  reg_req_in,
    output var  logic [7:0]               reg_rdata_out,
    // column latch writes and code reads
    input  wire flps_pkg::flps_latch_wr_t latch_wr_in,
    input  wire flps_pkg::flps_code_rd_t  code_rd_in,
    input  wire logic [7:0]               flash_rdata_in,
    output var  logic [7:0]               code_data_out,
    // user array macro and status
    output var  flps_pkg::flps_flash_op_t flash_op_out,
    output var  logic                     prog_busy_flag_out,
    // protection
    input  wire logic                     external_access_pin_in,
    input  wire logic                     parallel_mode_in,
    input  wire logic                     lock_wr_in,
    input  wire logic [2:0]               lock_data_in,
    input  wire logic                     pc_rollover_in,
    output var  flps_pkg::flps_prot_t     prot_out,
    output var  logic                     acc_eff_out,
    output var  logic                     ext_exec_block_out
);
    import flps_pkg::*;

    logic              rst_meta_r, rst_n_r;
    logic              acc_meta_r, acc_sync_r, par_meta_r, par_sync_r;
    logic              map_r, pend_r, busy_r, acc_cap_r;
    logic [1:0]        fmod_r, pend_mode_r, run_mode_r, acc_wait_r;
    logic [6:0]        idx_r;
    logic [5:0]        cnt_r;
    logic [8:0]        page_r;
    logic [127:0]      loaded_r;
    logic [7:0]        latch_r [128];
    logic [7:0]        xrow_r [128];
    logic [7:0]        hsb_r, rdata_r, code_r;
    flps_state_t       state_r;
    flps_flash_op_t    op_r;
    logic              wr_ctrl, first_ok, launch, lat_acc, cur_ld, step_end;

    // step length of the current phase in cycles
    function automatic logic [5:0] flps_len(input flps_state_t st);
        flps_len = (st == FLPS_ERASE) ? 6'(`FLPS_ERASE_CYC) : 6'(`FLPS_PROG_CYC);
    endfunction : flps_len

    // map decode of the mode bits, used only by the code-space reads
    function automatic logic flps_map(input logic map, input logic [1:0] fm,
                                      input logic [1:0] want);
        flps_map = !map && (fm == want);
    endfunction : flps_map

    ////////////////////////////////////////////////////////////////////
    // reset release through two flops, pins through two flops
    always_ff @(posedge ref_clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            acc_meta_r <= 1'b0;
            acc_sync_r <= 1'b0;
            par_meta_r <= 1'b0;
            par_sync_r <= 1'b0;
        end
        else
        begin
            acc_meta_r <= external_access_pin_in;
            acc_sync_r <= acc_meta_r;
            par_meta_r <= parallel_mode_in;
            par_sync_r <= par_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command decode; writes are ignored while a cycle runs
    assign wr_ctrl  = reg_req_in.wr && (reg_req_in.addr == `FLPS_CTRL_OFS) && !busy_r;
    assign first_ok = (reg_req_in.wdata[7:`FLPS_CMD_LSB] == `FLPS_CMD_FIRST)
                   && !reg_req_in.wdata[`FLPS_MAP_BIT] && !reg_req_in.wdata[0]
                   && (reg_req_in.wdata[2:1] != 2'h3);
    assign launch   = wr_ctrl && pend_r
                   && (reg_req_in.wdata == {`FLPS_CMD_SECOND, 1'b0, pend_mode_r, 1'b0});

    // pending first byte; any other write to the register drops it
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            pend_r      <= 1'b0;
            pend_mode_r <= `FLPS_MODE_USER;
        end
        else if (wr_ctrl)
        begin
            pend_r      <= first_ok;
            pend_mode_r <= reg_req_in.wdata[2:1];
        end
    end

    // map bits change only on writes with an empty command nibble
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            map_r  <= 1'(`FLPS_CTRL_RST >> `FLPS_MAP_BIT);
            fmod_r <= 2'(`FLPS_CTRL_RST >> `FLPS_FMOD_LSB);
        end
        else if (wr_ctrl && (reg_req_in.wdata[7:`FLPS_CMD_LSB] == 4'h0))
        begin
            map_r  <= reg_req_in.wdata[`FLPS_MAP_BIT];
            fmod_r <= reg_req_in.wdata[2:`FLPS_FMOD_LSB];
        end
    end

    // register read data, valid the cycle after the read strobe
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rdata_r <= 8'h00;
        end
        else if (reg_req_in.rd)
        begin
            rdata_r <= (reg_req_in.addr == `FLPS_CTRL_OFS)
                     ? {4'h0, map_r, fmod_r, busy_r} : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // column latches: any count of bytes, each marked when loaded
    assign lat_acc = latch_wr_in.wr && map_r && !busy_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            loaded_r <= '0;
            page_r   <= 9'h000;
        end
        else if (state_r == FLPS_DONE)
        begin
            loaded_r <= '0;
        end
        else if (lat_acc)
        begin
            loaded_r[latch_wr_in.addr[6:0]] <= 1'b1;
            page_r <= latch_wr_in.addr[15:7];
        end
    end

    // latch data has no reset: the mask says what is meaningful
    always_ff @(posedge ref_clk_in)
    begin
        if (lat_acc)
        begin
            latch_r[latch_wr_in.addr[6:0]] <= latch_wr_in.data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer: one pass erasing every loaded byte, then one programming
    assign cur_ld   = loaded_r[idx_r];
    assign step_end = !cur_ld || (cnt_r == flps_len(state_r) - 6'h01);

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            state_r    <= FLPS_IDLE;
            idx_r      <= 7'h00;
            cnt_r      <= 6'h00;
            run_mode_r <= `FLPS_MODE_USER;
        end
        else
        begin
            unique case (state_r)
                FLPS_IDLE:
                begin
                    if (launch)
                    begin
                        state_r    <= FLPS_ERASE;
                        idx_r      <= 7'h00;
                        cnt_r      <= 6'h00;
                        run_mode_r <= pend_mode_r;
                    end
                end
                FLPS_ERASE, FLPS_PROG:
                begin
                    if (step_end)
                    begin
                        cnt_r <= 6'h00;
                        idx_r <= idx_r + 7'h01;
                        if (idx_r == `FLPS_LAST_IDX)
                        begin
                            // program only after all erases
                            state_r <= (state_r == FLPS_ERASE) ? FLPS_PROG : FLPS_DONE;
                        end
                    end
                    else
                    begin
                        cnt_r <= cnt_r + 6'h01;
                    end
                end
                FLPS_DONE:
                begin
                    state_r <= FLPS_IDLE;
                end
            endcase
        end
    end

    // busy spans launch to the end of the pass
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            busy_r <= 1'b0;
        end
        else if (launch)
        begin
            busy_r <= 1'b1;
        end
        else if (state_r == FLPS_DONE)
        begin
            busy_r <= 1'b0;
        end
    end

    // user array strobes to the macro, one cycle behind the sequencer
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            op_r <= '0;
        end
        else
        begin
            op_r.erase <= (state_r == FLPS_ERASE) && cur_ld
                       && (run_mode_r == `FLPS_MODE_USER);
            op_r.prog  <= (state_r == FLPS_PROG) && cur_ld
                       && (run_mode_r == `FLPS_MODE_USER);
            op_r.addr  <= {page_r[7:0], idx_r};
            op_r.data  <= latch_r[idx_r];
        end
    end

    // extra row cells, updated at the end of each loaded step
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            for (int i = 0; i < 128; i++)
            begin
                xrow_r[i] <= `FLPS_ERASED;
            end
        end
        else if (cur_ld && step_end && (run_mode_r == `FLPS_MODE_XROW))
        begin
            xrow_r[idx_r] <= (state_r == FLPS_ERASE) ? `FLPS_ERASED
                                                     : latch_r[idx_r];
        end
    end

    // security byte; software programming never touches the lock bits
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            hsb_r <= `FLPS_HSB_RST;
        end
        else if (lock_wr_in && par_sync_r)
        begin
            hsb_r[2:0] <= lock_data_in;
        end
        else if (cur_ld && step_end && (idx_r == 7'h00)
                 && (run_mode_r == `FLPS_MODE_HSB))
        begin
            hsb_r <= (hsb_r & `FLPS_LB_MASK) | (~`FLPS_LB_MASK &
                     ((state_r == FLPS_ERASE) ? `FLPS_ERASED : latch_r[0]));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // protection decode and access pin capture after reset release
    flps_lock_decode u_lock
    (
        .lock_bits_in (hsb_r[2:0]),
        .prot_out     (prot_out)
    );

    // wait for the pin sync to fill before freezing its value
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            acc_wait_r <= 2'h0;
            acc_cap_r  <= 1'b0;
        end
        else if (acc_wait_r != 2'h3)
        begin
            acc_wait_r <= acc_wait_r + 2'h1;
            acc_cap_r  <= acc_sync_r;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            acc_eff_out        <= 1'b0;
            ext_exec_block_out <= 1'b0;
        end
        else
        begin
            acc_eff_out <= prot_out.acc_latch ? acc_cap_r : acc_sync_r;
            ext_exec_block_out <= prot_out.roll_block && pc_rollover_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // code-space reads, answered one cycle later
    always_ff @(posedge ref_clk_in or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            code_r <= 8'h00;
        end
        else if (code_rd_in.rd)
        begin
            if (code_rd_in.from_ext && prot_out.ext_read_bar)
            begin
                code_r <= `FLPS_BARRED;
            end
            else if (flps_map(map_r, fmod_r, `FLPS_MODE_XROW)
                     && (code_rd_in.addr >= `FLPS_XROW_BASE))
            begin
                code_r <= xrow_r[code_rd_in.addr[6:0]];
            end
            else if (flps_map(map_r, fmod_r, `FLPS_MODE_HSB)
                     && (code_rd_in.addr == `FLPS_HSB_ADDR))
            begin
                code_r <= hsb_r;
            end
            else
            begin
                code_r <= flash_rdata_in;
            end
        end
    end

    assign reg_rdata_out      = rdata_r;
    assign code_data_out      = code_r;
    assign flash_op_out       = op_r;
    assign prog_busy_flag_out = busy_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_r);

    a_busy_launch: assert property (launch |=> busy_r [*8])
        else $error("busy not held after launch");
    a_pair_order: assert property ($rose(busy_r) |-> $past(pend_r))
        else $error("launch without first byte");
    a_busy_end: assert property ($fell(busy_r) |-> $past(state_r) == FLPS_DONE)
        else $error("busy cleared early");
    a_user_cmd: assert property ($rose(busy_r) && run_mode_r == 2'h0
        |-> $past(reg_req_in.wdata) == 8'hA0)
        else $error("user launch byte wrong");
    a_xrow_cmd: assert property ($rose(busy_r) && run_mode_r == 2'h1
        |-> $past(reg_req_in.wdata) == 8'hA2)
        else $error("extra row launch byte wrong");
    a_hsb_cmd: assert property ($rose(busy_r) && run_mode_r == 2'h2
        |-> $past(reg_req_in.wdata) == 8'hA4)
        else $error("security launch byte wrong");
    a_erase_first: assert property (state_r == FLPS_PROG |=> state_r != FLPS_ERASE)
        else $error("erase after program");
    a_erase_loaded: assert property (op_r.erase |-> $past(cur_ld))
        else $error("erase of unloaded byte");
    a_page_addr: assert property (op_r.prog |-> op_r.addr[14:7] == page_r[7:0])
        else $error("program page mismatch");
    a_ext_bar: assert property (code_rd_in.rd && code_rd_in.from_ext
        && prot_out.level >= 3'h2 |=> code_data_out == 8'hFF)
        else $error("external read not barred");
    a_hsb_read: assert property (code_rd_in.rd && !code_rd_in.from_ext
        && {map_r, fmod_r} == 3'b010
        && code_rd_in.addr == 16'h0000 |=> code_data_out == $past(hsb_r))
        else $error("security byte not mapped");
    a_lock_hold: assert property (!par_sync_r |=> $stable(hsb_r[2:0]))
        else $error("lock bits changed outside parallel mode");
    a_roll_block: assert property (prot_out.level == 3'h4 && pc_rollover_in
        |=> ext_exec_block_out)
        else $error("rollover not blocked");

    c_user_prog: cover property ($fell(busy_r) && run_mode_r == 2'h0);
    c_xrow_prog: cover property ($fell(busy_r) && run_mode_r == 2'h1);
    c_hsb_prog: cover property ($fell(busy_r) && run_mode_r == 2'h2);
    c_full_page: cover property (launch && (&loaded_r));
endmodule : flps_sequencer
`default_nettype wire

// ### flps_array_model.sv
/*
  flps_array_model.sv: behavioural user array macro beside the sequencer.
  Assumes erase and program steps arrive on the sequencer clock.
*/
`default_nettype none
module flps_array_model
(
    // clock and macro port
    input  wire logic                     ref_clk_in,
    input  wire flps_pkg::flps_flash_op_t op_in,
    input  wire logic [14:0]              rd_addr_in,
    output var  logic [7:0]               rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import flps_pkg::*;
    logic [7:0] mem_r [0:32767];
    // seed pattern, so a stray erase shows up as FFh
    initial
    begin
        for (int i = 0; i < 32768; i++)
            mem_r[i] = i[7:0] ^ 8'h5A;
    end
    // program only clears bits, so a skipped erase leaves a wrong byte
    always @(posedge ref_clk_in)
    begin
        if (op_in.erase)
            mem_r[op_in.addr] <= 8'hFF;
        else if (op_in.prog)
            mem_r[op_in.addr] <= mem_r[op_in.addr] & op_in.data;
    end
    assign rdata_out = mem_r[rd_addr_in];
endmodule : flps_array_model
`default_nettype wire

// ### flash_latch_program_sequencer_tb.sv
/*
  flash_latch_program_sequencer_tb.sv: bench playing the programming software.
  Assumes the array model answers user array code reads.
*/
`default_nettype none
module flash_latch_program_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flps_pkg::*;
    logic           ref_clk_in = 1'b0;
    logic           rstn_in    = 1'b0;
    flps_reg_req_t  rq         = '0;
    flps_latch_wr_t lw         = '0;
    flps_code_rd_t  cr         = '0;
    flps_flash_op_t fop;
    flps_prot_t     prot;
    logic [7:0]     rdat, cdat, frd, pg, d1, d2;
    logic [2:0]     lkd        = 3'h0;
    logic [2:0]     lb [4]     = '{3'h7, 3'h6, 3'h5, 3'h3};
    logic           busy, acc_eff, blk;
    logic           acc_pin    = 1'b0;
    logic           par = 1'b0, lkw = 1'b0, roll = 1'b0;
    int             err_total  = 0;
    int             checks     = 0;
    int             cyc        = 0;
    // reference model: latch bytes of the current load, programmed user bytes
    logic [7:0]     mdl_lat [int];
    logic [7:0]     mdl_mem [int];
    int             mdl_pg     = 0;
    initial
    begin
        forever #20 ref_clk_in = ~ref_clk_in;
    end
    flps_sequencer DUT (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_req_in(rq),
        .reg_rdata_out(rdat), .latch_wr_in(lw), .code_rd_in(cr), .flash_rdata_in(frd),
        .code_data_out(cdat), .flash_op_out(fop), .prog_busy_flag_out(busy),
        .external_access_pin_in(acc_pin), .parallel_mode_in(par), .lock_wr_in(lkw),
        .lock_data_in(lkd), .pc_rollover_in(roll), .prot_out(prot),
        .acc_eff_out(acc_eff), .ext_exec_block_out(blk));
    flps_array_model u_array (.ref_clk_in(ref_clk_in), .op_in(fop),
        .rd_addr_in(cr.addr[14:0]), .rdata_out(frd));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // unprogrammed user bytes keep the array's seed pattern
    function automatic logic [7:0] exp_user(input logic [14:0] a);
        exp_user = mdl_mem.exists(a) ? mdl_mem[a] : a[7:0] ^ 8'h5A;
    endfunction : exp_user
    // every strobe is one cycle long, raised and dropped right after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        rq <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_in);
        rq.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        rq <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_in);
        rq.rd <= 1'b0;
        #1 cmp("reg", e, rdat);
    endtask : rd
    task automatic ld(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        lw <= '{1'b1, a, d};
        mdl_lat[a[6:0]] = d;
        mdl_pg = a[15:7];
        @(posedge ref_clk_in);
        lw.wr <= 1'b0;
    endtask : ld
    task automatic cd(input logic [15:0] a, input logic x, input logic [7:0] e);
        @(posedge ref_clk_in);
        cr <= '{1'b1, x, a};
        @(posedge ref_clk_in);
        cr.rd <= 1'b0;
        #1 cmp("code", e, cdat);
    endtask : cd
    // launch, then poll under a bound; m is the map and mode left in place
    task automatic go(input logic [7:0] x, input logic [7:0] m);
        int n;
        n = 0;
        wr(8'h00, 8'h50 | x);
        wr(8'h00, 8'hA0 | x);
        #1 cmp("busy", 8'h01, {7'h0, busy});
        while (busy === 1'b1 && n < 3000)
        begin
            @(posedge ref_clk_in);
            #1 n++;
        end
        // a user launch writes every loaded byte into the last page
        foreach (mdl_lat[k])
            if (x == 8'h00)
                mdl_mem[{mdl_pg[7:0], k[6:0]}] = mdl_lat[k];
        mdl_lat.delete();
        rd(8'h00, m);
    endtask : go
    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, well above the roughly 1200 cycles the tests need
    always @(posedge ref_clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            report_and_stop();
        end
    end
    initial
    begin
        d1 = $urandom(32'h9cb7);
        repeat (3) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        rd(8'h00, 8'h00);
        wr(8'h10, 8'h55);
        rd(8'h10, 8'h00);
        cmp("level", 8'h04, {5'h0, prot.level});
        wr(8'h00, 8'h04);
        cd(16'h0000, 1'b0, 8'hFB);
        wr(8'h00, 8'h00);
        cd(16'h0000, 1'b0, exp_user(15'h0000));
        $display("test reset done");
        pg = $urandom % 256;
        d1 = $urandom;
        d2 = $urandom;
        wr(8'h00, 8'h08);
        ld({1'b0, pg ^ 8'h01, 7'h05}, d1);
        ld({1'b0, pg, 7'h05}, d1);
        ld({1'b0, pg, 7'h05}, d2);
        ld({1'b0, pg, 7'h7F}, d1);
        go(8'h00, 8'h08);
        wr(8'h00, 8'h00);
        cd({1'b0, pg, 7'h05}, 1'b0, exp_user({pg, 7'h05}));
        cd({1'b0, pg, 7'h7F}, 1'b0, exp_user({pg, 7'h7F}));
        cd({1'b0, pg, 7'h00}, 1'b0, exp_user({pg, 7'h00}));
        cd({1'b0, pg ^ 8'h01, 7'h05}, 1'b0, exp_user({pg ^ 8'h01, 7'h05}));
        $display("test user done");
        wr(8'h00, 8'h50);
        wr(8'h00, 8'h08);
        wr(8'h00, 8'hA0);
        #1 cmp("busy", 8'h00, {7'h0, busy});
        wr(8'h00, 8'h50);
        wr(8'h00, 8'hA2);
        #1 cmp("busy", 8'h00, {7'h0, busy});
        $display("test order done");
        ld({9'h1FF, d1[6:0]}, d2);
        go(8'h02, 8'h08);
        wr(8'h00, 8'h02);
        cd({9'h1FF, d1[6:0]}, 1'b0, d2);
        cd({9'h1FF, d1[6:0] ^ 7'h01}, 1'b0, 8'hFF);
        wr(8'h00, 8'h00);
        cd({9'h1FF, d1[6:0]}, 1'b0, exp_user({8'hFF, d1[6:0]}));
        wr(8'h00, 8'h0C);
        ld(16'h0000, d1);
        go(8'h04, 8'h0C);
        wr(8'h00, 8'h04);
        cd(16'h0000, 1'b0, {d1[7:3], 3'b011});
        $display("test spaces done");
        @(posedge ref_clk_in);
        lkw <= 1'b1;
        lkd <= 3'h7;
        @(posedge ref_clk_in);
        lkw <= 1'b0;
        par <= 1'b1;
        roll <= 1'b1;
        acc_pin <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        #1 cmp("level", 8'h04, {5'h0, prot.level});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge ref_clk_in);
            lkw <= 1'b1;
            lkd <= lb[i];
            @(posedge ref_clk_in);
            lkw <= 1'b0;
            #1 cmp("level", 8'(i + 1), {5'h0, prot.level});
            cmp("prot", {4'h0, i > 0, i > 0, i > 1, i > 2}, {4'h0, prot.ext_read_bar,
                prot.par_prog_dis, prot.par_verify_dis, prot.roll_block});
            cd({1'b0, pg, 7'h05}, 1'b1, (i == 0) ? exp_user({pg, 7'h05}) : 8'hFF);
            cmp("block", {7'h0, i == 3}, {7'h0, blk});
            cmp("access", {7'h0, i == 0}, {7'h0, acc_eff});
        end
        @(posedge ref_clk_in);
        roll <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1 cmp("block", 8'h01, {7'h0, blk});
        $display("test protection done");
        report_and_stop();
    end
endmodule : flash_latch_program_sequencer_tb
`default_nettype wire
